/* File: core/tmr_pkg.sv */
package tmr_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] TMR_ADDR_CTRL = 8'h88;
    localparam logic [7:0] TMR_ADDR_MODE = 8'h89;
    localparam logic [7:0] TMR_ADDR_A_LO = 8'h8A;
    localparam logic [7:0] TMR_ADDR_B_LO = 8'h8B;
    localparam logic [7:0] TMR_ADDR_A_HI = 8'h8C;
    localparam logic [7:0] TMR_ADDR_B_HI = 8'h8D;

    // ****************************************
    // control register bit positions
    // ****************************************
    localparam int TMR_BIT_B_OVF = 7;
    localparam int TMR_BIT_B_RUN = 6;
    localparam int TMR_BIT_A_OVF = 5;
    localparam int TMR_BIT_A_RUN = 4;
    localparam int TMR_BIT_XB_FLAG = 3;
    localparam int TMR_BIT_XB_TYPE = 2;
    localparam int TMR_BIT_XA_FLAG = 1;
    localparam int TMR_BIT_XA_TYPE = 0;

    // ****************************************
    // mode register field positions
    // ****************************************
    localparam int TMR_MODE_A_LSB = 0;
    localparam int TMR_MODE_A_SRC = 2;
    localparam int TMR_MODE_A_GATE = 3;
    localparam int TMR_MODE_B_LSB = 4;
    localparam int TMR_MODE_B_SRC = 6;
    localparam int TMR_MODE_B_GATE = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] TMR_CTRL_RST = 8'h00;
    localparam logic [7:0] TMR_MODE_RST = 8'h00;
    localparam logic [7:0] TMR_CNT_RST = 8'h00;

    // operating modes, encoding as in the mode field
    typedef enum logic [1:0] {
        TMR_MODE_13 = 2'h0,
        TMR_MODE_16 = 2'h1,
        TMR_MODE_RELOAD = 2'h2,
        TMR_MODE_SPLIT = 2'h3
    } tmr_mode_e;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic irqB;
        logic irqA;
        logic evtB;
        logic evtA;
    } tmr_pins_s;

    typedef struct packed {
        logic rdEn;
        logic wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
        logic bitWr;
        logic [2:0] bitIdx;
        logic bitVal;
    } tmr_sfr_req_s;

    typedef struct packed {
        logic extB;
        logic timerB;
        logic extA;
        logic timerA;
    } tmr_ack_s;

    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } tmr_step_s;

    typedef struct packed {
        tmr_pins_s s1;
        tmr_pins_s s2;
    } tmr_sync_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] aLo;
        logic [7:0] aHi;
        logic [7:0] bLo;
        logic [7:0] bHi;
        logic [7:0] rdData;
        logic bTick;
    } tmr_state_s;

    // active level of an interrupt pin under its polarity bit
    function automatic logic tmr_pin_active(input logic lvl, input logic pol);
        tmr_pin_active = ~(lvl ^ pol);
    endfunction

endpackage

/* File: core/tmr_sync.sv */
`timescale 1ns/1ps
module tmr_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // raw pins and their synchronised copy
    input wire tmr_pkg::tmr_pins_s pinRaw,
    output tmr_pkg::tmr_pins_s pinSync
);
    import tmr_pkg::*;

    tmr_sync_s st_ff;
    tmr_sync_s nxt_st;

    // two stages; only the second stage leaves the module
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pinRaw;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pinSync = st_ff.s2;
endmodule

/* File: core/tmr_edge_det.sv */
`timescale 1ns/1ps
module tmr_edge_det (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // synchronised levels in, one-cycle edge pulses out
    input wire tmr_pkg::tmr_pins_s lvl,
    output tmr_pkg::tmr_pins_s rise,
    output tmr_pkg::tmr_pins_s fall
);
    import tmr_pkg::*;

    tmr_pins_s prev_ff;
    tmr_pins_s nxt_prev;

    // previous level, the only state here
    always_comb begin
        nxt_prev = lvl;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    // a pin held low through reset gives no spurious fall
    assign rise = lvl & ~prev_ff;
    assign fall = ~lvl & prev_ff;
endmodule

/* File: core/tmr_split_timer.sv */
`timescale 1ns/1ps
module tmr_split_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // special function register port
    input wire tmr_pkg::tmr_sfr_req_s sfrReq,
    output logic [7:0] sfrRdData,
    // pins: event inputs and external interrupt inputs
    input wire tmr_pkg::tmr_pins_s pinRaw,
    // polarity and clock source configuration
    input wire logic extIrqAPolarity,
    input wire logic extIrqBPolarity,
    input wire logic timerASysClk,
    input wire logic timerBSysClk,
    input wire logic prescaleTick,
    // vector acknowledges from the processor
    input wire tmr_pkg::tmr_ack_s vecAck,
    // interrupt requests and overflow tick
    output logic timerAIrq,
    output logic timerBIrq,
    output logic extIrqAReq,
    output logic extIrqBReq,
    output logic timerBOvfTick
);
    import tmr_pkg::*;

    // ****************************************
    // pin conditioning
    // ****************************************
    tmr_pins_s pinSync;
    tmr_pins_s pinRise;
    tmr_pins_s pinFall;

    tmr_sync u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinRaw(pinRaw),
        .pinSync(pinSync)
    );

    tmr_edge_det u_edge (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .lvl(pinSync),
        .rise(pinRise),
        .fall(pinFall)
    );

    // ****************************************
    // counting helpers
    // ****************************************
    // one increment of a timer in modes 0 to 2; mode 3 holds
    function automatic tmr_step_s tmr_step(input tmr_mode_e m, input logic [7:0] hi, input logic [7:0] lo);
        tmr_step_s r;
        logic [12:0] c13;
        logic [15:0] c16;
        logic [7:0] c8;
        r = '{ovf: 1'b0, hi: hi, lo: lo};
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        c8 = lo + 8'h01;
        unique case (m)
            TMR_MODE_13: begin
                r.ovf = &{hi, lo[4:0]};
                r.hi = c13[12:5];
                r.lo = {lo[7:5], c13[4:0]};
            end
            TMR_MODE_16: begin
                r.ovf = &{hi, lo};
                r.hi = c16[15:8];
                r.lo = c16[7:0];
            end
            TMR_MODE_RELOAD: begin
                r.ovf = &lo;
                r.lo = (&lo) ? hi : c8;
            end
            TMR_MODE_SPLIT: begin
                r.ovf = 1'b0;
            end
        endcase
        return r;
    endfunction

    // register read mux; unmapped addresses read zero
    function automatic logic [7:0] tmr_read(input tmr_state_s s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == TMR_ADDR_CTRL) d = s.ctrl;
        if (a == TMR_ADDR_MODE) d = s.mode;
        if (a == TMR_ADDR_A_LO) d = s.aLo;
        if (a == TMR_ADDR_A_HI) d = s.aHi;
        if (a == TMR_ADDR_B_LO) d = s.bLo;
        if (a == TMR_ADDR_B_HI) d = s.bHi;
        return d;
    endfunction

    tmr_state_s st_ff;
    tmr_state_s nxt_st;

    // ****************************************
    // decode of modes, sources and gates
    // ****************************************
    tmr_mode_e modeA;
    tmr_mode_e modeB;
    logic split;
    logic actA;
    logic actB;
    logic edgeA;
    logic edgeB;
    logic intTickA;
    logic intTickB;
    logic lowTick;
    logic hiTick;
    logic bTick;
    logic lowOvf;
    logic hiOvf;
    logic bOvf;
    tmr_step_s stepA;
    tmr_step_s stepB;
    logic wrCtrl;
    logic wrAnyA;
    logic wrAnyB;

    assign modeA = tmr_mode_e'(st_ff.mode[TMR_MODE_A_LSB +: 2]);
    assign modeB = tmr_mode_e'(st_ff.mode[TMR_MODE_B_LSB +: 2]);
    assign split = (modeA == TMR_MODE_SPLIT);
    // polarity picks the active level and edge
    assign actA = tmr_pin_active(pinSync.irqA, extIrqAPolarity);
    assign actB = tmr_pin_active(pinSync.irqB, extIrqBPolarity);
    assign edgeA = extIrqAPolarity ? pinRise.irqA : pinFall.irqA;
    assign edgeB = extIrqBPolarity ? pinRise.irqB : pinFall.irqB;
    assign intTickA = timerASysClk | prescaleTick;
    assign intTickB = timerBSysClk | prescaleTick;
    // low byte source, run and gate
    assign lowTick = st_ff.ctrl[TMR_BIT_A_RUN] & (~st_ff.mode[TMR_MODE_A_GATE] | actA)
        & (st_ff.mode[TMR_MODE_A_SRC] ? pinFall.evtA : intTickA);
    // high byte: internal clock, timer B run bit
    assign hiTick = split & st_ff.ctrl[TMR_BIT_B_RUN] & intTickA;
    // timer B run: mode field in split, else run and gate
    assign bTick = (modeB != TMR_MODE_SPLIT)
        & (split ? intTickB : (st_ff.ctrl[TMR_BIT_B_RUN] & (~st_ff.mode[TMR_MODE_B_GATE] | actB)
        & (st_ff.mode[TMR_MODE_B_SRC] ? pinFall.evtB : intTickB)));
    assign stepA = tmr_step(modeA, st_ff.aHi, st_ff.aLo);
    assign stepB = tmr_step(modeB, st_ff.bHi, st_ff.bLo);
    assign lowOvf = lowTick & (split ? (&st_ff.aLo) : stepA.ovf);
    assign hiOvf = hiTick & (&st_ff.aHi);
    assign bOvf = bTick & stepB.ovf;
    assign wrCtrl = sfrReq.wrEn & (sfrReq.addr == TMR_ADDR_CTRL);
    assign wrAnyA = sfrReq.wrEn & ((sfrReq.addr == TMR_ADDR_A_LO) | (sfrReq.addr == TMR_ADDR_A_HI));
    assign wrAnyB = sfrReq.wrEn & ((sfrReq.addr == TMR_ADDR_B_LO) | (sfrReq.addr == TMR_ADDR_B_HI));

    // ****************************************
    // next state
    // ****************************************
    // order: count, software write, vector clear, hardware set;
    // so a flag event in the clearing cycle is never lost
    always_comb begin
        nxt_st = st_ff;
        nxt_st.bTick = bOvf;
        // two byte counters in split, one timer otherwise
        if (split) begin
            if (lowTick) nxt_st.aLo = st_ff.aLo + 8'h01;
            if (hiTick) nxt_st.aHi = st_ff.aHi + 8'h01;
        end else if (lowTick) begin
            nxt_st.aLo = stepA.lo;
            nxt_st.aHi = stepA.hi;
        end
        // mode 3 gives no tick, count holds
        if (bTick) begin
            nxt_st.bLo = stepB.lo;
            nxt_st.bHi = stepB.hi;
        end
        if (sfrReq.wrEn) begin
            if (sfrReq.addr == TMR_ADDR_MODE) nxt_st.mode = sfrReq.wrData;
            if (sfrReq.addr == TMR_ADDR_A_LO) nxt_st.aLo = sfrReq.wrData;
            if (sfrReq.addr == TMR_ADDR_A_HI) nxt_st.aHi = sfrReq.wrData;
            if (sfrReq.addr == TMR_ADDR_B_LO) nxt_st.bLo = sfrReq.wrData;
            if (sfrReq.addr == TMR_ADDR_B_HI) nxt_st.bHi = sfrReq.wrData;
        end
        // whole-byte write of the control byte
        if (wrCtrl) nxt_st.ctrl = sfrReq.wrData;
        // bit write touches one bit only
        if (sfrReq.bitWr) nxt_st.ctrl[sfrReq.bitIdx] = sfrReq.bitVal;
        if (vecAck.timerA) nxt_st.ctrl[TMR_BIT_A_OVF] = 1'b0;
        if (vecAck.timerB) nxt_st.ctrl[TMR_BIT_B_OVF] = 1'b0;
        // vector clears only edge-type irq flags
        if (vecAck.extA & st_ff.ctrl[TMR_BIT_XA_TYPE]) nxt_st.ctrl[TMR_BIT_XA_FLAG] = 1'b0;
        if (vecAck.extB & st_ff.ctrl[TMR_BIT_XB_TYPE]) nxt_st.ctrl[TMR_BIT_XB_FLAG] = 1'b0;
        // timer A overflow sets its flag
        if (lowOvf) nxt_st.ctrl[TMR_BIT_A_OVF] = 1'b1;
        // in split only the high byte sets the B flag
        if (split ? hiOvf : bOvf) nxt_st.ctrl[TMR_BIT_B_OVF] = 1'b1;
        // edge latches, level follows the pin
        if (st_ff.ctrl[TMR_BIT_XA_TYPE]) begin
            if (edgeA) nxt_st.ctrl[TMR_BIT_XA_FLAG] = 1'b1;
        end else begin
            nxt_st.ctrl[TMR_BIT_XA_FLAG] = actA;
        end
        if (st_ff.ctrl[TMR_BIT_XB_TYPE]) begin
            if (edgeB) nxt_st.ctrl[TMR_BIT_XB_FLAG] = 1'b1;
        end else begin
            nxt_st.ctrl[TMR_BIT_XB_FLAG] = actB;
        end
        // read data stands for one cycle after the strobe
        nxt_st.rdData = sfrReq.rdEn ? tmr_read(st_ff, sfrReq.addr) : 8'h00;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '{ctrl: TMR_CTRL_RST, mode: TMR_MODE_RST, aLo: TMR_CNT_RST, aHi: TMR_CNT_RST,
                bLo: TMR_CNT_RST, bHi: TMR_CNT_RST, rdData: 8'h00, bTick: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs all come from the state register
    assign sfrRdData = st_ff.rdData;
    assign timerAIrq = st_ff.ctrl[TMR_BIT_A_OVF];
    assign timerBIrq = st_ff.ctrl[TMR_BIT_B_OVF];
    assign extIrqAReq = st_ff.ctrl[TMR_BIT_XA_FLAG];
    assign extIrqBReq = st_ff.ctrl[TMR_BIT_XB_FLAG];
    // tick keeps flowing while the B flag is blocked
    assign timerBOvfTick = st_ff.bTick;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic quietCtrl;
    assign quietCtrl = ~wrCtrl & ~sfrReq.bitWr;

    sequence s_hi_wrap;
        hiTick && st_ff.aHi == 8'hFF;
    endsequence

    sequence s_b_flag_up;
        st_ff.ctrl[TMR_BIT_B_OVF] && timerBIrq;
    endsequence

    property p_hi_sets_b;
        s_hi_wrap |=> s_b_flag_up && (st_ff.aHi == 8'h00 || $past(wrAnyA));
    endproperty
    a_hi_sets_b: assert property (p_hi_sets_b) else $error("high byte wrap did not set B flag");

    property p_hi_needs_run;
        split && !st_ff.ctrl[TMR_BIT_B_RUN] && !wrAnyA |=> $stable(st_ff.aHi);
    endproperty
    a_hi_needs_run: assert property (p_hi_needs_run) else $error("high byte moved without B run");

    property p_b_silent;
        split && !hiOvf && quietCtrl && !st_ff.ctrl[TMR_BIT_B_OVF] |=> !timerBIrq;
    endproperty
    a_b_silent: assert property (p_b_silent) else $error("timer B set its own flag in split");

    property p_tick_out;
        split && bOvf |=> timerBOvfTick ##1 !timerBOvfTick || $past(bOvf);
    endproperty
    a_tick_out: assert property (p_tick_out) else $error("timer B tick missing in split");

    property p_b_hold;
        split && modeB == TMR_MODE_SPLIT && !wrAnyB |=> $stable({st_ff.bHi, st_ff.bLo});
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("timer B counted in mode 3");

    property p_low_event;
        split && st_ff.ctrl[TMR_BIT_A_RUN] && !st_ff.mode[TMR_MODE_A_GATE] && st_ff.mode[TMR_MODE_A_SRC]
            && pinFall.evtA && !wrAnyA |=> st_ff.aLo == 8'($past(st_ff.aLo) + 8'h01);
    endproperty
    a_low_event: assert property (p_low_event) else $error("low byte missed an event edge");

    property p_a_stop;
        !st_ff.ctrl[TMR_BIT_A_RUN] && !split && !wrAnyA |=> $stable({st_ff.aHi, st_ff.aLo});
    endproperty
    a_a_stop: assert property (p_a_stop) else $error("timer A counted while stopped");

    property p_a_flag;
        lowOvf |=> timerAIrq;
    endproperty
    a_a_flag: assert property (p_a_flag) else $error("timer A overflow lost");

    property p_edge_set;
        st_ff.ctrl[TMR_BIT_XB_TYPE] && edgeB |=> extIrqBReq;
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("irq B edge not latched");

    property p_edge_clear;
        st_ff.ctrl[TMR_BIT_XB_TYPE] && vecAck.extB && !edgeB && !sfrReq.bitWr && !wrCtrl |=> !extIrqBReq;
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("irq B flag not cleared by vector");

    property p_level_follow;
        !st_ff.ctrl[TMR_BIT_XB_TYPE] |=> extIrqBReq == $past(actB);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level irq B flag off the pin");

    property p_bit_only;
        sfrReq.bitWr && !wrCtrl && sfrReq.bitIdx != 3'(TMR_BIT_B_RUN)
            |=> st_ff.ctrl[TMR_BIT_B_RUN] == $past(st_ff.ctrl[TMR_BIT_B_RUN]);
    endproperty
    a_bit_only: assert property (p_bit_only) else $error("bit write disturbed B run");
endmodule

/* File: tb/tmr_pin_model.sv */
`timescale 1ns/1ps
// ****************************************
// far side: event pins and interrupt pins
// ****************************************
module tmr_pin_model (
    // clock
    input wire logic mclk,
    // pins toward the timer
    output tmr_pkg::tmr_pins_s pins
);
    import tmr_pkg::*;

    // event pins idle high, interrupt pins idle low
    initial begin
        pins = '{irqB: 1'b0, irqA: 1'b0, evtB: 1'b1, evtA: 1'b1};
    end

    // both event pins fall together; hold stays >= 2 so no edge is lost in the sync
    task automatic evt_burst(input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            #1 {pins.evtA, pins.evtB} = 2'b00;
            repeat (hold) @(posedge mclk);
            #1 {pins.evtA, pins.evtB} = 2'b11;
            repeat (hold) @(posedge mclk);
        end
    endtask

    // interrupt levels, changed just after an edge
    task automatic set_irq(input logic a, input logic b);
        @(posedge mclk);
        #1 pins.irqA = a;
        pins.irqB = b;
    endtask
endmodule

/* File: tb/test_split_timer_mode_and_timer_control.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin nErrors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module test_split_timer_mode_and_timer_control;
    import tmr_pkg::*;

    logic mclk, sys_rst, extIrqAPolarity, extIrqBPolarity, prescaleTick, sysClk;
    logic timerAIrq, timerBIrq, extIrqAReq, extIrqBReq, timerBOvfTick;
    logic [7:0] sfrRdData;
    logic [7:0] mc; // model of the control byte
    tmr_sfr_req_s sfrReq;
    tmr_ack_s vecAck;
    tmr_pins_s pinRaw;
    int nErrors, testsRun, ovfTicks, sa, sh, n, m;

    tmr_split_timer i_dut (.mclk(mclk), .sys_rst(sys_rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
        .pinRaw(pinRaw), .extIrqAPolarity(extIrqAPolarity), .extIrqBPolarity(extIrqBPolarity),
        .timerASysClk(sysClk), .timerBSysClk(sysClk), .prescaleTick(prescaleTick), .vecAck(vecAck),
        .timerAIrq(timerAIrq), .timerBIrq(timerBIrq), .extIrqAReq(extIrqAReq),
        .extIrqBReq(extIrqBReq), .timerBOvfTick(timerBOvfTick));
    tmr_pin_model i_pins (.mclk(mclk), .pins(pinRaw));

    // ****************************************
    // clock, tick counter, watchdog
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // counted here since the pulse stands one cycle only
    always @(posedge mclk) begin
        if (timerBOvfTick === 1'b1) ovfTicks++;
    end

    // run needs under 500 cycles of the 20000 allowed, so this is generous
    initial begin
        #(25 * 20000);
        nErrors++;
        stopTest();
    end

    // ****************************************
    // bus and stimulus tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 sfrReq.wrEn = 1'b1;
        sfrReq.addr = a;
        sfrReq.wrData = d;
        @(posedge mclk);
        #1 sfrReq.wrEn = 1'b0;
    endtask

    task automatic bitw(input int idx, input logic v);
        mc[idx] = v;
        @(posedge mclk);
        #1 sfrReq.bitWr = 1'b1;
        sfrReq.bitIdx = 3'(idx);
        sfrReq.bitVal = v;
        @(posedge mclk);
        #1 sfrReq.bitWr = 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        #1 sfrReq.rdEn = 1'b1;
        sfrReq.addr = a;
        @(posedge mclk);
        #1 sfrReq.rdEn = 1'b0;
        `CHK(sfrRdData, e)
    endtask

    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge mclk);
            #1 prescaleTick = 1'b1;
            @(posedge mclk);
            #1 prescaleTick = 1'b0;
        end
    endtask

    task automatic ack(input tmr_ack_s v);
        @(posedge mclk);
        #1 vecAck = v;
        @(posedge mclk);
        #1 vecAck = '0;
    endtask

    task automatic stopTest();
        if (nErrors == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        sfrReq = '0;
        vecAck = '0;
        prescaleTick = 1'b0;
        sysClk = 1'b0;
        extIrqAPolarity = 1'b1;
        extIrqBPolarity = 1'b1;
        mc = 8'h00;
        n = $urandom(93);
        sys_rst = 1'b1;
        repeat (10) @(posedge mclk);
        #1 sys_rst = 1'b0;
        // reset values and an unmapped place
        for (int a = 136; a <= 141; a++) chkrd(8'(a), 8'h00);
        wr(8'h90, 8'hFF);
        chkrd(8'h90, 8'h00);
        chkrd(TMR_ADDR_CTRL, mc);
        // split mode, both halves near overflow
        wr(TMR_ADDR_MODE, 8'h03);
        bitw(TMR_BIT_A_RUN, 1'b1);
        bitw(TMR_BIT_B_RUN, 1'b1);
        chkrd(TMR_ADDR_CTRL, mc);
        repeat (3) begin
            sa = 240 + $urandom_range(15, 0);
            sh = 240 + $urandom_range(15, 0);
            n = $urandom_range(20, 1);
            wr(TMR_ADDR_A_LO, 8'(sa));
            wr(TMR_ADDR_A_HI, 8'(sh));
            ticks(n);
            if (sa + n > 255) mc[TMR_BIT_A_OVF] = 1'b1;
            if (sh + n > 255) mc[TMR_BIT_B_OVF] = 1'b1;
            chkrd(TMR_ADDR_A_LO, 8'(sa + n));
            chkrd(TMR_ADDR_A_HI, 8'(sh + n));
            chkrd(TMR_ADDR_CTRL, mc);
            `CHK(timerAIrq, mc[TMR_BIT_A_OVF])
            `CHK(timerBIrq, mc[TMR_BIT_B_OVF])
            ack('{extB: 1'b0, timerB: 1'b0, extA: 1'b0, timerA: 1'b1});
            mc[TMR_BIT_A_OVF] = 1'b0;
            bitw(TMR_BIT_B_OVF, 1'b0);
            chkrd(TMR_ADDR_CTRL, mc);
        end
        // high byte halts without the second run bit
        bitw(TMR_BIT_B_RUN, 1'b0);
        wr(TMR_ADDR_A_LO, 8'h20);
        wr(TMR_ADDR_A_HI, 8'h40);
        ticks(5);
        chkrd(TMR_ADDR_A_LO, 8'h25);
        chkrd(TMR_ADDR_A_HI, 8'h40);
        // low byte on events, high byte on ticks only
        bitw(TMR_BIT_B_RUN, 1'b1);
        wr(TMR_ADDR_MODE, 8'h07);
        wr(TMR_ADDR_A_LO, 8'h10);
        m = $urandom_range(8, 1);
        i_pins.evt_burst(m, $urandom_range(4, 2));
        repeat (4) @(posedge mclk);
        chkrd(TMR_ADDR_A_LO, 8'(16 + m));
        chkrd(TMR_ADDR_A_HI, 8'h40);
        ticks(2);
        chkrd(TMR_ADDR_A_LO, 8'(16 + m));
        chkrd(TMR_ADDR_A_HI, 8'h42);
        // gate on interrupt pin a, level flag follows it
        wr(TMR_ADDR_MODE, 8'h0B);
        ticks(4);
        chkrd(TMR_ADDR_A_LO, 8'(16 + m));
        i_pins.set_irq(1'b1, 1'b0);
        repeat (4) @(posedge mclk);
        mc[TMR_BIT_XA_FLAG] = 1'b1;
        ticks(4);
        chkrd(TMR_ADDR_A_LO, 8'(20 + m));
        chkrd(TMR_ADDR_CTRL, mc);
        `CHK(extIrqAReq, 1'b1)
        i_pins.set_irq(1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        mc[TMR_BIT_XA_FLAG] = 1'b0;
        // second timer overflows in split: tick yes, flag no
        wr(TMR_ADDR_MODE, 8'h03);
        wr(TMR_ADDR_A_HI, 8'h00);
        wr(TMR_ADDR_B_HI, 8'hFF);
        wr(TMR_ADDR_B_LO, 8'h1F);
        ovfTicks = 0;
        ticks(1);
        repeat (2) @(posedge mclk);
        `CHK(ovfTicks, 1)
        chkrd(TMR_ADDR_CTRL, mc);
        // mode 3 stops the second timer and keeps its count
        wr(TMR_ADDR_MODE, 8'h33);
        wr(TMR_ADDR_B_LO, 8'h55);
        ticks(3);
        chkrd(TMR_ADDR_B_LO, 8'h55);
        `CHK(ovfTicks, 1)
        // interrupt b: edge type, then level type, then polarity
        bitw(TMR_BIT_XB_TYPE, 1'b1);
        i_pins.set_irq(1'b0, 1'b1);
        repeat (4) @(posedge mclk);
        mc[TMR_BIT_XB_FLAG] = 1'b1;
        chkrd(TMR_ADDR_CTRL, mc);
        i_pins.set_irq(1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        chkrd(TMR_ADDR_CTRL, mc);
        ack('{extB: 1'b1, timerB: 1'b0, extA: 1'b0, timerA: 1'b0});
        mc[TMR_BIT_XB_FLAG] = 1'b0;
        chkrd(TMR_ADDR_CTRL, mc);
        i_pins.set_irq(1'b0, 1'b1);
        repeat (4) @(posedge mclk);
        bitw(TMR_BIT_XB_FLAG, 1'b0);
        chkrd(TMR_ADDR_CTRL, mc);
        bitw(TMR_BIT_XB_TYPE, 1'b0);
        mc[TMR_BIT_XB_FLAG] = 1'b1;
        chkrd(TMR_ADDR_CTRL, mc);
        i_pins.set_irq(1'b0, 1'b0);
        repeat (4) @(posedge mclk);
        mc[TMR_BIT_XB_FLAG] = 1'b0;
        chkrd(TMR_ADDR_CTRL, mc);
        @(posedge mclk);
        #1 extIrqBPolarity = 1'b0;
        repeat (4) @(posedge mclk);
        mc[TMR_BIT_XB_FLAG] = 1'b1;
        chkrd(TMR_ADDR_CTRL, mc);
        `CHK(extIrqBReq, 1'b1)
        // high byte on the raw system clock; timer B in mode 3 must ignore it
        wr(TMR_ADDR_A_HI, 8'h10);
        m = $urandom_range(8, 1);
        @(posedge mclk);
        #1 sysClk = 1'b1;
        repeat (m) @(posedge mclk);
        #1 sysClk = 1'b0;
        chkrd(TMR_ADDR_A_HI, 8'(16 + m));
        chkrd(TMR_ADDR_B_LO, 8'h55);
        stopTest();
    end
endmodule
